//--- pkg/kiu_pkg.sv
// shared constants for the keypad interrupt unit
package kiu_pkg;

  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] KIU_IDX_STATUS_CTRL = 8'h1a;  // key_status_control
  localparam logic [7:0] KIU_IDX_PIN_ENABLE  = 8'h1b;  // key_pin_enable_reg
  localparam logic [7:0] KIU_IDX_BREAK_CTRL  = 8'h1c;  // break_flag_ctrl_reg
  localparam logic [7:0] KIU_IDX_INT_STATUS  = 8'h1d;  // sticky event bits
  localparam logic [7:0] KIU_IDX_INT_MASK    = 8'h1e;  // event enables

  // field positions inside key_status_control
  localparam int KIU_BIT_PENDING = 3;  // key_pending_flag, read only
  localparam int KIU_BIT_ACK     = 2;  // key_ack_bit, write only
  localparam int KIU_BIT_MASK    = 1;  // key_irq_mask
  localparam int KIU_BIT_LEVEL   = 0;  // key_trigger_level_sel

  // field position inside break_flag_ctrl_reg
  localparam int KIU_BIT_BRK_CLR = 7;  // break_clear_allow

  // event bits inside the interrupt status and mask registers
  localparam int KIU_EVT_LATCH = 0;  // a request was latched
  localparam int KIU_EVT_ACK   = 1;  // a request was acknowledged
  localparam int KIU_EVT_W     = 2;  // number of event bits

  // reset values
  localparam logic [4:0] KIU_RST_ENABLES = 5'h00;
  localparam logic [1:0] KIU_RST_EVT     = 2'h0;

  // ahb transfer type code for a single transfer
  localparam logic [1:0] KIU_HTRANS_NONSEQ = 2'h2;

  // word byte address of a register index
  function automatic logic [9:0] kiu_addr(input logic [7:0] idx);
    kiu_addr = {idx, 2'b00};
  endfunction

endpackage

//--- src/kiu_keypad_irq.sv
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
// Summary of operation
// - break clear allowed: ack clears, stays cleared
// - break clear blocked: ack writes in break ignored
// - status upper 28 bits read zero
// - pending flag shows latched request, reset clears
// - ack write of one clears, reads zero
// - mask set blocks cpu request, reset clears
// - level select: edges plus lows, else edges
// - five enables gate pins, reset clears all
// - latch only when pins go low from all-high
// - vector fetch acts as ack; edge mode immediate
// - level mode clears after ack and pins high
// - new falling edge after ack latches again
module kiu_keypad_irq
  import kiu_pkg::*;
#(
  parameter int NPINS = 5  // number of keypad pins
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [NPINS-1:0]  key_pins,
  input  wire logic              break_state,
  input  wire logic              vector_ack,
  output logic                   key_irq,
  output logic                   irq
);

  // pin synchroniser stages
  logic [NPINS-1:0] key_meta;       // first stage, read only by second
  logic [NPINS-1:0] key_sync;       // second stage, safe to use
  // keyboard state
  logic [NPINS-1:0] key_pin_enables;
  logic             req;            // latched request, key_pending_flag
  logic             ack_seen;       // level mode: ack taken, pins still low
  logic             prev_low;       // some enabled pin was low last cycle
  logic             key_irq_mask;
  logic             key_trigger_level_sel;
  logic             break_clear_allow;
  logic [KIU_EVT_W-1:0] int_status; // sticky events
  logic [KIU_EVT_W-1:0] int_mask;   // event enables
  // bus data phase state
  logic             wr_pend;        // a write data phase is due
  logic [7:0]       wr_idx;         // register index of that write
  // next values
  logic [NPINS-1:0] next_enables;
  logic             next_req;
  logic             next_ack_seen;
  logic             next_mask;
  logic             next_level;
  logic             next_brk_allow;
  logic [KIU_EVT_W-1:0] next_int_status;
  logic [KIU_EVT_W-1:0] next_int_mask;
  logic             next_wr_pend;
  logic [7:0]       next_wr_idx;
  logic [31:0]      next_hrdata;
  // decode helpers
  logic             addr_phase;     // valid transfer addressed to us
  logic [7:0]       addr_idx;       // index of the addressed register
  logic             en_low;         // some enabled pin low now
  logic             latch_set;      // new request this cycle
  logic             sw_ack_try;     // software writes one to the ack bit
  logic             sw_ack;         // that write takes effect
  logic             ack;            // any acknowledge this cycle
  logic             wr_ksc;         // data phase write of status/control

  // two flop synchroniser on the key pins
  // reset to the released level, so that no false falling edge follows reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      key_meta <= '1;
      key_sync <= '1;
    end else begin
      key_meta <= key_pins;
      key_sync <= key_meta;
    end
  end

  // address phase decode
  always_comb begin
    addr_phase = hsel && hready && (htrans == KIU_HTRANS_NONSEQ);
    addr_idx   = haddr[9:2];
  end

  // pin detection and acknowledge sources
  always_comb begin
    en_low     = |(~key_sync & key_pin_enables);
    latch_set  = en_low && !prev_low;
    wr_ksc     = wr_pend && (wr_idx == KIU_IDX_STATUS_CTRL);
    sw_ack_try = wr_ksc && hwdata[KIU_BIT_ACK];
    // protected break state drops the ack write
    sw_ack     = sw_ack_try && !(break_state && !break_clear_allow);
    ack        = sw_ack || vector_ack;
  end

  // request latch next state
  always_comb begin
    next_req      = req;
    next_ack_seen = ack_seen;
    if (!key_trigger_level_sel) begin
      // edge only: an ack clears at once
      next_ack_seen = 1'b0;
      if (ack) begin
        next_req = 1'b0;
      end
    end else begin
      // edge and level: need ack and all pins high, any order
      if (ack && req) begin
        next_ack_seen = 1'b1;
      end
      if ((ack || ack_seen) && !en_low) begin
        next_req      = 1'b0;
        next_ack_seen = 1'b0;
      end
    end
    // a fresh falling edge wins over any clear
    if (latch_set) begin
      next_req      = 1'b1;
      next_ack_seen = 1'b0;
    end
  end

  // request latch registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      req      <= 1'b0;
      ack_seen <= 1'b0;
      prev_low <= 1'b0;
      key_irq  <= 1'b0;
    end else begin
      req      <= next_req;
      ack_seen <= next_ack_seen;
      prev_low <= en_low;
      key_irq  <= next_req && !next_mask;
    end
  end

  // control register writes in the data phase
  always_comb begin
    next_enables   = key_pin_enables;
    next_mask      = key_irq_mask;
    next_level     = key_trigger_level_sel;
    next_brk_allow = break_clear_allow;
    next_int_mask  = int_mask;
    if (wr_ksc) begin
      next_mask  = hwdata[KIU_BIT_MASK];
      next_level = hwdata[KIU_BIT_LEVEL];
    end
    if (wr_pend && (wr_idx == KIU_IDX_PIN_ENABLE)) begin
      next_enables = hwdata[NPINS-1:0];
    end
    if (wr_pend && (wr_idx == KIU_IDX_BREAK_CTRL)) begin
      next_brk_allow = hwdata[KIU_BIT_BRK_CLR];
    end
    if (wr_pend && (wr_idx == KIU_IDX_INT_MASK)) begin
      next_int_mask = hwdata[KIU_EVT_W-1:0];
    end
  end

  // control registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      key_pin_enables       <= KIU_RST_ENABLES;
      key_irq_mask          <= 1'b0;
      key_trigger_level_sel <= 1'b0;
      break_clear_allow     <= 1'b0;
      int_mask              <= KIU_RST_EVT;
    end else begin
      key_pin_enables       <= next_enables;
      key_irq_mask          <= next_mask;
      key_trigger_level_sel <= next_level;
      break_clear_allow     <= next_brk_allow;
      int_mask              <= next_int_mask;
    end
  end

  // sticky events: a read clears them, a new event wins
  always_comb begin
    next_int_status = int_status;
    if (addr_phase && !hwrite && (addr_idx == KIU_IDX_INT_STATUS)) begin
      next_int_status = '0;
    end
    if (latch_set) begin
      next_int_status[KIU_EVT_LATCH] = 1'b1;
    end
    if (ack && req) begin
      next_int_status[KIU_EVT_ACK] = 1'b1;
    end
  end

  // event registers and interrupt line
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      int_status <= KIU_RST_EVT;
      irq        <= 1'b0;
    end else begin
      int_status <= next_int_status;
      irq        <= |(next_int_status & next_int_mask);
    end
  end

  // bus slave: read data chosen in the address phase, writes held for data phase
  always_comb begin
    next_wr_pend = addr_phase && hwrite;
    next_wr_idx  = addr_idx;
    next_hrdata  = hrdata;
    if (addr_phase && !hwrite) begin
      next_hrdata = '0;  // unmapped reads return zero
      unique case (addr_idx)
        KIU_IDX_STATUS_CTRL: begin
          // upper bits and the ack bit always read zero
          next_hrdata[KIU_BIT_PENDING] = req;
          next_hrdata[KIU_BIT_MASK]    = key_irq_mask;
          next_hrdata[KIU_BIT_LEVEL]   = key_trigger_level_sel;
        end
        KIU_IDX_PIN_ENABLE: begin
          next_hrdata[NPINS-1:0] = key_pin_enables;
        end
        KIU_IDX_BREAK_CTRL: begin
          next_hrdata[KIU_BIT_BRK_CLR] = break_clear_allow;
        end
        KIU_IDX_INT_STATUS: begin
          next_hrdata[KIU_EVT_W-1:0] = int_status;
        end
        KIU_IDX_INT_MASK: begin
          next_hrdata[KIU_EVT_W-1:0] = int_mask;
        end
        default: begin
          next_hrdata = '0;
        end
      endcase
    end
  end

  // bus slave registers; always ready, always okay
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_pend   <= 1'b0;
      wr_idx    <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= next_wr_pend;
      wr_idx    <= next_wr_idx;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // checks ------------------------------------------------------------
  // a read address phase of the status and control register
  sequence s_read_ksc;
    addr_phase && !hwrite && (addr_idx == KIU_IDX_STATUS_CTRL);
  endsequence

  // a software ack refused in break; a remembered level ack may still clear
  sequence s_protected_ack;
    sw_ack_try && break_state && !break_clear_allow && !vector_ack && !latch_set
      && !ack_seen;
  endsequence

  // any acknowledge in edge only mode with no fresh edge
  sequence s_edge_ack;
    ack && !key_trigger_level_sel && !latch_set;
  endsequence

  // an acknowledge in level mode while an enabled pin is still low
  sequence s_level_ack;
    key_trigger_level_sel && ack && req && en_low && !latch_set;
  endsequence

  // register bus answers at once and never with an error
  AST_BUS_OKAY: assert property (@(posedge mclk) disable iff (!rst_n)
    hreadyout && !hresp)
    else $error("bus slave not ready or not okay");

  // level mode keeps the request and remembers the ack
  AST_LEVEL_KEEP: assert property (@(posedge mclk) disable iff (!rst_n)
    s_level_ack |=> (req && ack_seen))
    else $error("level mode ack lost or cleared early");

  AST_UPPER_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    s_read_ksc |=> (hrdata[31:4] == 28'h000_0000))
    else $error("status upper bits not zero");

  AST_PENDING_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    s_read_ksc |=> (hrdata[KIU_BIT_PENDING] == $past(req)))
    else $error("pending flag read mismatch");

  AST_ACK_READS_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    s_read_ksc |=> !hrdata[KIU_BIT_ACK])
    else $error("ack bit read as one");

  AST_BREAK_PROTECT: assert property (@(posedge mclk) disable iff (!rst_n)
    s_protected_ack |=> (req == $past(req)))
    else $error("ack took effect in protected break");

  AST_BREAK_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
    (sw_ack_try && break_state && break_clear_allow) and s_edge_ack |=> !req)
    else $error("allowed break clear failed");

  AST_EDGE_ACK: assert property (@(posedge mclk) disable iff (!rst_n)
    s_edge_ack |=> !req)
    else $error("edge mode ack did not clear");

  // cpu request follows the pending flag unless masked
  AST_MASK_GATE: assert property (@(posedge mclk) disable iff (!rst_n)
    key_irq == (req && !key_irq_mask))
    else $error("cpu request not gated by mask");

  AST_LATCH_CAUSE: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(req) |-> $past(en_low && !prev_low))
    else $error("request latched without falling edge");

  AST_LEVEL_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    (key_trigger_level_sel && req && en_low) |=> req)
    else $error("level request dropped while pin low");

  // every fresh edge latches, also right after an ack, and leaves its event
  AST_REARM: assert property (@(posedge mclk) disable iff (!rst_n)
    latch_set |=> (req && int_status[KIU_EVT_LATCH]))
    else $error("edge after ack not latched");

  AST_IGNORE_DISABLED: assert property (@(posedge mclk) disable iff (!rst_n)
    (key_pin_enables == '0) |-> !latch_set)
    else $error("disabled pins latched request");

  // second stage follows the first one cycle later
  AST_SYNC_DEPTH: assert property (@(posedge mclk) disable iff (!rst_n)
    ##2 (key_sync == $past(key_meta)))
    else $error("synchroniser depth wrong");

  // reset leaves edge only mode and no request
  AST_LEVEL_RESET: assert property (@(posedge mclk)
    !rst_n |=> !key_trigger_level_sel && !req)
    else $error("reset left level select or request set");

endmodule // kiu_keypad_irq

//--- testbench/keypad_interrupt_unit_tb.sv
`timescale 1ns/1ps
module keypad_interrupt_unit_tb;
  import kiu_pkg::*;
  // row: enables, {mask,level}, pins pressed before and after an ack, pending
  typedef struct packed {
    logic [4:0] en;
    logic [1:0] ctl;
    logic [4:0] pa;
    logic [4:0] pb;
    logic       pend;
  } kiu_row_t;
  logic        mclk, rst_n, hsel, hwrite, break_state, vector_ack;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [4:0]  press, key_pins;
  logic        hreadyout, hresp, key_irq, irq;
  int          errors, checks;
  kiu_row_t    rows [6] = '{
    '{5'h1f, 2'h0, 5'h00, 5'h01, 1'b1}, '{5'h1f, 2'h0, 5'h02, 5'h03, 1'b0},
    '{5'h1e, 2'h0, 5'h00, 5'h01, 1'b0}, '{5'h1f, 2'h1, 5'h02, 5'h02, 1'b1},
    '{5'h10, 2'h0, 5'h00, 5'h10, 1'b1}, '{5'h1f, 2'h2, 5'h00, 5'h04, 1'b1}};

  kiu_keypad_irq uut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .key_pins(key_pins), .break_state(break_state), .vector_ack(vector_ack),
    .key_irq(key_irq), .irq(irq));
  kiu_key_model keys (.mclk(mclk), .press(press), .key_pins(key_pins));

  // 250 MHz clock
  always #2 mclk = ~mclk;

  // verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // compare a register word
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  // compare an output line
  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: line %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // bounded wait for hready sampled high at a rising edge
  task automatic bus_wait();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      errors++;
      $display("wrong value at %0t: bus never ready", $time);
      results();
    end
  endtask
  // one single transfer: address phase, then data phase
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, kiu_addr(idx)};
    hwrite <= wr;
    htrans <= KIU_HTRANS_NONSEQ;
    bus_wait();
    htrans <= 2'h0;
    hwdata <= wd;
    bus_wait();
    rd = hrdata;
  endtask
  // read a register and compare it
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 32'h0);
    chk32(rd, exp);
  endtask
  // one-cycle vector fetch acknowledge
  task automatic vec();
    vector_ack <= 1'b1;
    cyc(1);
    vector_ack <= 1'b0;
    cyc(3);
  endtask

  initial begin
    mclk = 0;
    rst_n = 0;
    {hsel, hwrite, break_state, vector_ack} = '0;
    {haddr, hwdata, htrans, press} = '0;
    errors = 0;
    checks = 0;
    cyc(10);
    rst_n <= 1'b1;
    cyc(1);
    // table: enables, trigger mode, mask and pin patterns
    foreach (rows[i]) begin
      press <= 5'h00;
      cyc(5);
      bus(KIU_IDX_PIN_ENABLE, 1'b1, {27'h0, rows[i].en});
      bus(KIU_IDX_STATUS_CTRL, 1'b1, {29'h1, rows[i].ctl});
      press <= rows[i].pa;
      cyc(5);
      bus(KIU_IDX_STATUS_CTRL, 1'b1, {29'h1, rows[i].ctl});
      press <= rows[i].pb;
      cyc(5);
      rdc(KIU_IDX_STATUS_CTRL, {28'h0, rows[i].pend, 1'b0, rows[i].ctl});
      chk1(key_irq, rows[i].pend & ~rows[i].ctl[1]);
      $display("row %0d done", i);
    end
    // reset in mid-run clears every register
    rst_n <= 1'b0;
    cyc(10);
    rst_n <= 1'b1;
    cyc(1);
    rdc(KIU_IDX_STATUS_CTRL, 32'h0);
    rdc(KIU_IDX_PIN_ENABLE, 32'h0);
    rdc(KIU_IDX_BREAK_CTRL, 32'h0);
    rdc(KIU_IDX_INT_MASK, 32'h0);
    rdc(KIU_IDX_INT_STATUS, 32'h0);
    chk1(key_irq, 1'b0);
    chk1(irq, 1'b0);
    chk1(hresp, 1'b0);
    chk1(hreadyout, 1'b1);
    bus(8'h1f, 1'b1, 32'hffff_ffff);
    rdc(8'h1f, 32'h0);
    $display("reset test done");
    // break state: ack refused, then allowed and kept
    bus(KIU_IDX_PIN_ENABLE, 1'b1, 32'h1f);
    press <= 5'h01;
    cyc(5);
    break_state <= 1'b1;
    bus(KIU_IDX_STATUS_CTRL, 1'b1, 32'h4);
    rdc(KIU_IDX_STATUS_CTRL, 32'h8);
    bus(KIU_IDX_BREAK_CTRL, 1'b1, 32'h80);
    bus(KIU_IDX_STATUS_CTRL, 1'b1, 32'h4);
    rdc(KIU_IDX_STATUS_CTRL, 32'h0);
    break_state <= 1'b0;
    cyc(2);
    rdc(KIU_IDX_STATUS_CTRL, 32'h0);
    $display("break test done");
    // vector fetch clears at once in edge mode, later edge latches again
    press <= 5'h03;
    cyc(5);
    rdc(KIU_IDX_STATUS_CTRL, 32'h0);
    press <= 5'h00;
    cyc(5);
    press <= 5'h02;
    cyc(5);
    vec();
    rdc(KIU_IDX_STATUS_CTRL, 32'h0);
    press <= 5'h00;
    cyc(5);
    press <= 5'h04;
    cyc(5);
    rdc(KIU_IDX_STATUS_CTRL, 32'h8);
    $display("vector test done");
    // level mode: vector ack first, pins return high afterwards
    press <= 5'h00;
    bus(KIU_IDX_STATUS_CTRL, 1'b1, 32'h5);
    press <= 5'h08;
    cyc(5);
    vec();
    rdc(KIU_IDX_STATUS_CTRL, 32'h9);
    press <= 5'h00;
    cyc(5);
    rdc(KIU_IDX_STATUS_CTRL, 32'h1);
    $display("level test done");
    // event interrupt: held off by mask, raised, cleared by status read
    bus(KIU_IDX_STATUS_CTRL, 1'b1, 32'h4);
    bus(KIU_IDX_INT_STATUS, 1'b0, 32'h0);
    press <= 5'h10;
    cyc(5);
    chk1(irq, 1'b0);
    bus(KIU_IDX_INT_MASK, 1'b1, 32'h1);
    cyc(2);
    chk1(irq, 1'b1);
    rdc(KIU_IDX_INT_STATUS, 32'h1);
    cyc(3);
    chk1(irq, 1'b0);
    $display("interrupt test done");
    results();
  end
endmodule // keypad_interrupt_unit_tb

//--- testbench/kiu_key_model.sv
`timescale 1ns/1ps
// key switch bank: a held key pulls its line low, a released key lets the
// pull-up return it high; lines move a little after the edge, unsynchronised
module kiu_key_model (
  input  wire logic       mclk,
  input  wire logic [4:0] press,    // high = key held down
  output logic      [4:0] key_pins  // pulled-up key lines
);
  // lines start released
  initial key_pins = 5'h1f;
  // switch contacts settle 1 ns after the clock edge
  always @(posedge mclk) begin
    key_pins <= #1 ~press;
  end
endmodule // kiu_key_model
